// File: rtl/scl_cfg.svh
// Purpose: constants for the serial computer link host controller
// Assumes: 250 MHz pclk, character UART outside this block
// Notes:   offsets are byte addresses on the APB register window
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

`define SCL_STX        8'h02
`define SCL_ETX        8'h03
`define SCL_EOT        8'h04
`define SCL_ENQ        8'h05
`define SCL_ACK        8'h06
`define SCL_LF         8'h0a
`define SCL_CLEAR_CODE 8'h0c
`define SCL_CR         8'h0d
`define SCL_NAK        8'h15

`define SCL_CTRL_NO    4'hf
`define SCL_MULTI_WAIT 4'h7

`define SCL_A_CTRL     8'h00
`define SCL_A_CMD      8'h04
`define SCL_A_TXDATA   8'h08
`define SCL_A_STATUS   8'h0c
`define SCL_A_RXDATA   8'h10

`define SCL_C_START    0
`define SCL_C_FMT4     1
`define SCL_C_SUMEN    2
`define SCL_C_READ     3
`define SCL_C_ABORT    4
`define SCL_C_FLUSH    5
`define SCL_C_MULTI    6
`define SCL_C_STN_LO   8
`define SCL_C_WAIT_LO  12

`define SCL_CLK_MHZ    250
`define SCL_GAP_US     100
`define SCL_GAP_CYC    (`SCL_GAP_US * `SCL_CLK_MHZ)
`define SCL_RESP_MS    1000
`define SCL_RESP_CYC   (`SCL_RESP_MS * 1000 * `SCL_CLK_MHZ)
`define SCL_DEPTH      16

`endif

// File: rtl/scl_pkg.sv
// Purpose: types shared by the serial computer link host controller
// Assumes: binary state codes
// Notes:   constants live in scl_cfg.svh
package scl_pkg;

  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_SEND = 2'b01,
    SCL_RESP = 2'b10,
    SCL_GAP  = 2'b11
  } scl_state_t;

  typedef enum logic [3:0] {
    TP_LEAD = 4'b0000, TP_STH = 4'b0001, TP_STL = 4'b0010, TP_PCH = 4'b0011,
    TP_PCL  = 4'b0100, TP_CM1 = 4'b0101, TP_CM2 = 4'b0110, TP_WT  = 4'b0111,
    TP_DAT  = 4'b1000, TP_SMH = 4'b1001, TP_SML = 4'b1010, TP_CR  = 4'b1011,
    TP_LF   = 4'b1100, TP_END = 4'b1101
  } scl_tph_t;

  typedef enum logic [2:0] {
    RP_HUNT = 3'b000, RP_HDR = 3'b001, RP_DAT = 3'b010, RP_SMH = 3'b011,
    RP_SML  = 3'b100, RP_COD = 3'b101, RP_CR  = 3'b110, RP_LF  = 3'b111
  } scl_rph_t;

  typedef enum logic [1:0] {
    K_REQ   = 2'b00,
    K_CLOSE = 2'b01,
    K_CLR   = 2'b10
  } scl_kind_t;

endpackage : scl_pkg

// File: rtl/scl_hex.sv
// Purpose: ASCII hex digit encode and decode
// Assumes: upper-case digits only
// Notes:   purely combinational
`timescale 1ns/1ns
module scl_hex (
  input  wire logic [3:0] nib_in,
  output logic      [7:0] asc_out,
  input  wire logic [7:0] asc_in,
  output logic      [3:0] nib_out
);

  always_comb begin
    if (nib_in < 4'ha) begin
      asc_out = 8'h30 + {4'h0, nib_in};
    end else begin
      asc_out = 8'h37 + {4'h0, nib_in};
    end
  end

  // anything outside 0-9/A-F decodes to zero and fails the sum compare unless that sum nibble is zero
  always_comb begin
    if (asc_in >= 8'h30 && asc_in <= 8'h39) begin
      nib_out = asc_in[3:0];
    end else if (asc_in >= 8'h41 && asc_in <= 8'h46) begin
      nib_out = asc_in[3:0] + 4'h9;
    end else begin
      nib_out = 4'h0;
    end
  end

endmodule : scl_hex

// File: rtl/scl_host.sv
// Purpose: host end of the serial computer link, driven by software over APB
// Assumes: a UART outside moves the characters; tx/rx ports carry whole bytes
// Notes:   payload bytes are already-encoded ASCII supplied by software
`timescale 1ns/1ns
`include "scl_cfg.svh"
module scl_host
  import scl_pkg::*;
#(
  parameter int          DEPTH    = `SCL_DEPTH,
  parameter logic [31:0] GAP_CYC  = `SCL_GAP_CYC,
  parameter logic [31:0] RESP_CYC = `SCL_RESP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             busy
);

  localparam int IW = $clog2(DEPTH);

  typedef struct packed {
    scl_state_t             st;
    scl_tph_t               ph;
    scl_rph_t               rph;
    scl_kind_t              kind;
    logic [7:0]             lead;
    logic [IW:0]            didx;
    logic [7:0]             sum;
    logic [31:0]            tmr;
    logic [3:0]             stn;
    logic [3:0]             wt;
    logic                   fmt4;
    logic                   sum_en;
    logic                   rd;
    logic                   multi;
    logic [15:0]            cmd;
    logic [DEPTH-1:0][7:0]  txb;
    logic [IW:0]            txlen;
    logic [DEPTH-1:0][7:0]  rxb;
    logic [IW:0]            rxlen;
    logic [IW:0]            rxptr;
    logic [7:0]             rkind;
    logic [7:0]             rsum;
    logic [3:0]             rsh;
    logic [1:0]             rcnt;
    logic                   done;
    logic                   nak;
    logic                   serr;
    logic                   tmo;
    logic                   ok;
    logic                   txv;
    logic [7:0]             txd;
    logic                   pack;
    logic [31:0]            prd;
    logic                   perr;
  } scl_host_t;

  scl_host_t s_r;
  scl_host_t s_nxt;

  logic [3:0] enc_nib;
  logic [7:0] enc_asc;
  logic [3:0] dec_nib;
  logic [3:0] wt_eff;
  logic [7:0] chr;
  logic       apb_go;

  scl_hex u_hex (
    .nib_in  (enc_nib),
    .asc_out (enc_asc),
    .asc_in  (rx_data),
    .nib_out (dec_nib)
  );

  // multidrop one-pair lines need the longer turnaround
  assign wt_eff = (s_r.multi && s_r.wt < `SCL_MULTI_WAIT) ? `SCL_MULTI_WAIT : s_r.wt;

  ////////////////////////////////////////////////////////////////////////////
  // character of the current transmit phase

  always_comb begin
    enc_nib = 4'h0;
    chr     = 8'h00;
    case (s_r.ph)
      TP_LEAD: chr = s_r.lead;
      TP_STH: begin
        enc_nib = 4'h0;
        chr     = enc_asc;
      end
      TP_STL: begin
        enc_nib = s_r.stn;
        chr     = enc_asc;
      end
      TP_PCH, TP_PCL: begin
        enc_nib = `SCL_CTRL_NO;
        chr     = enc_asc;
      end
      TP_CM1: chr = s_r.cmd[15:8];
      TP_CM2: chr = s_r.cmd[7:0];
      TP_WT: begin
        enc_nib = wt_eff;
        chr     = enc_asc;
      end
      TP_DAT: chr = s_r.txb[s_r.didx[IW-1:0]];
      TP_SMH: begin
        enc_nib = s_r.sum[7:4];
        chr     = enc_asc;
      end
      TP_SML: begin
        enc_nib = s_r.sum[3:0];
        chr     = enc_asc;
      end
      TP_CR:   chr = `SCL_CR;
      TP_LF:   chr = `SCL_LF;
      default: chr = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign apb_go = psel && penable && s_r.pack;

  always_comb begin
    logic     tail;
    logic     fin;
    scl_tph_t tl;
    tail  = 1'b0;
    fin   = 1'b0;
    s_nxt = s_r;
    tl    = s_r.fmt4 ? TP_CR : TP_END;
    case (s_r.st)
      SCL_IDLE: s_nxt.tmr = 32'h0;
      SCL_SEND: begin
        if (!s_r.txv || tx_ready) begin
          if (s_r.ph == TP_END) begin
            s_nxt.txv = 1'b0;
            s_nxt.tmr = 32'h0;
            if (s_r.kind == K_REQ) begin
              s_nxt.st  = SCL_RESP;
              s_nxt.rph = RP_HUNT;
            end else begin
              s_nxt.st   = SCL_GAP;
              s_nxt.done = 1'b1;
            end
          end else begin
            s_nxt.txv = 1'b1;
            s_nxt.txd = chr;
            if (s_r.kind == K_REQ && s_r.ph >= TP_STH && s_r.ph <= TP_DAT) begin
              s_nxt.sum = s_r.sum + chr;
            end
            case (s_r.ph)
              TP_LEAD: s_nxt.ph = (s_r.kind == K_CLR) ? TP_END : TP_STH;
              TP_STH:  s_nxt.ph = TP_STL;
              TP_STL:  s_nxt.ph = TP_PCH;
              TP_PCH:  s_nxt.ph = TP_PCL;
              TP_PCL:  s_nxt.ph = (s_r.kind == K_CLOSE) ? tl : TP_CM1;
              TP_CM1:  s_nxt.ph = TP_CM2;
              TP_CM2:  s_nxt.ph = TP_WT;
              TP_WT: begin
                if (s_r.txlen != '0) begin
                  s_nxt.ph = TP_DAT;
                end else begin
                  s_nxt.ph = s_r.sum_en ? TP_SMH : tl;
                end
              end
              TP_DAT: begin
                s_nxt.didx = s_r.didx + 1'b1;
                if (s_r.didx + 1'b1 == s_r.txlen) begin
                  s_nxt.ph = s_r.sum_en ? TP_SMH : tl;
                end
              end
              TP_SMH:  s_nxt.ph = TP_SML;
              TP_SML:  s_nxt.ph = tl;
              TP_CR:   s_nxt.ph = TP_LF;
              default: s_nxt.ph = TP_END;
            endcase
          end
        end
      end
      SCL_RESP: begin
        if (rx_valid) begin
          s_nxt.tmr = 32'h0;
          case (s_r.rph)
            RP_HUNT: begin
              // idle-line garbage and framing noise never start a reply
              if (rx_data == `SCL_STX || rx_data == `SCL_ACK || rx_data == `SCL_NAK) begin
                s_nxt.rkind = rx_data;
                s_nxt.rph   = RP_HDR;
                s_nxt.rcnt  = 2'd0;
                s_nxt.rsum  = 8'h00;
              end
            end
            RP_HDR: begin
              s_nxt.rsum = s_r.rsum + rx_data;
              s_nxt.rcnt = s_r.rcnt + 2'd1;
              if (s_r.rcnt == 2'd3) begin
                if (s_r.rkind == `SCL_STX) begin
                  s_nxt.rph = RP_DAT;
                end else if (s_r.rkind == `SCL_NAK) begin
                  s_nxt.rph  = RP_COD;
                  s_nxt.rcnt = 2'd0;
                end else begin
                  tail = 1'b1;
                end
              end
            end
            RP_DAT: begin
              s_nxt.rsum = s_r.rsum + rx_data;
              if (rx_data == `SCL_ETX) begin
                if (s_r.sum_en) begin
                  s_nxt.rph = RP_SMH;
                end else begin
                  tail = 1'b1;
                end
              end else if (s_r.rxlen < (IW+1)'(DEPTH)) begin
                s_nxt.rxb[s_r.rxlen[IW-1:0]] = rx_data;
                s_nxt.rxlen                  = s_r.rxlen + 1'b1;
              end
            end
            RP_SMH: begin
              s_nxt.rsh = dec_nib;
              s_nxt.rph = RP_SML;
            end
            RP_SML: begin
              if ({s_r.rsh, dec_nib} != s_r.rsum) begin
                s_nxt.serr = 1'b1;
              end
              tail = 1'b1;
            end
            RP_COD: begin
              if (s_r.rxlen < (IW+1)'(DEPTH)) begin
                s_nxt.rxb[s_r.rxlen[IW-1:0]] = rx_data;
                s_nxt.rxlen                  = s_r.rxlen + 1'b1;
              end
              s_nxt.rcnt = s_r.rcnt + 2'd1;
              tail       = (s_r.rcnt == 2'd1);
            end
            RP_CR:   s_nxt.rph = RP_LF;
            RP_LF:   fin = 1'b1;
            default: s_nxt.rph = RP_HUNT;
          endcase
          if (tail) begin
            if (s_r.fmt4) begin
              s_nxt.rph = RP_CR;
            end else begin
              fin = 1'b1;
            end
          end
          if (fin) begin
            s_nxt.rph = RP_HUNT;
            s_nxt.tmr = 32'h0;
            if (s_r.rkind == `SCL_STX && s_r.rd) begin
              // closing block: acknowledge good data, refuse a bad sum
              s_nxt.st   = SCL_SEND;
              s_nxt.kind = K_CLOSE;
              s_nxt.lead = s_nxt.serr ? `SCL_NAK : `SCL_ACK;
              s_nxt.ph   = TP_LEAD;
            end else begin
              s_nxt.st   = SCL_GAP;
              s_nxt.done = 1'b1;
              s_nxt.ok   = (s_r.rkind == `SCL_ACK);
              s_nxt.nak  = (s_r.rkind == `SCL_NAK);
            end
          end
        end else if (s_r.tmr == RESP_CYC - 32'd1) begin
          // silent device: end of transmission resets its sequence
          s_nxt.tmo  = 1'b1;
          s_nxt.st   = SCL_SEND;
          s_nxt.kind = K_CLR;
          s_nxt.lead = `SCL_EOT;
          s_nxt.ph   = TP_LEAD;
        end else begin
          s_nxt.tmr = s_r.tmr + 32'd1;
        end
      end
      SCL_GAP: begin
        if (s_r.tmr >= GAP_CYC - 32'd1) begin
          s_nxt.st = SCL_IDLE;
        end else begin
          s_nxt.tmr = s_r.tmr + 32'd1;
        end
      end
      default: s_nxt.st = SCL_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // apb slave: one wait cycle so read data comes from a flop

    s_nxt.pack = psel && penable && !s_r.pack;
    if (psel && penable && !s_r.pack) begin
      s_nxt.perr = 1'b0;
      case (paddr)
        `SCL_A_CTRL: begin
          s_nxt.prd = {16'h0, s_r.wt, s_r.stn, 1'b0, s_r.multi, 2'b0, s_r.rd,
                       s_r.sum_en, s_r.fmt4, 1'b0};
        end
        `SCL_A_CMD:    s_nxt.prd = {16'h0, s_r.cmd};
        `SCL_A_TXDATA: s_nxt.prd = {24'h0, 8'(s_r.txlen)};
        `SCL_A_STATUS: begin
          s_nxt.prd = {16'h0, 8'(s_r.rxlen), 2'b0, s_r.ok, s_r.tmo, s_r.serr,
                       s_r.nak, s_r.done, s_r.st != SCL_IDLE};
        end
        `SCL_A_RXDATA: begin
          s_nxt.prd = (s_r.rxptr < s_r.rxlen) ? {24'h0, s_r.rxb[s_r.rxptr[IW-1:0]]} : 32'h0;
        end
        default: begin
          s_nxt.prd  = 32'h0;
          s_nxt.perr = 1'b1;
        end
      endcase
    end
    if (apb_go && !pwrite && paddr == `SCL_A_RXDATA && s_r.rxptr < s_r.rxlen) begin
      s_nxt.rxptr = s_r.rxptr + 1'b1;
    end
    if (apb_go && pwrite && s_r.st == SCL_IDLE) begin
      case (paddr)
        `SCL_A_CTRL: begin
          s_nxt.fmt4   = pwdata[`SCL_C_FMT4];
          s_nxt.sum_en = pwdata[`SCL_C_SUMEN];
          s_nxt.rd     = pwdata[`SCL_C_READ];
          s_nxt.multi  = pwdata[`SCL_C_MULTI];
          s_nxt.stn    = pwdata[`SCL_C_STN_LO +: 4];
          s_nxt.wt     = pwdata[`SCL_C_WAIT_LO +: 4];
          if (pwdata[`SCL_C_FLUSH]) begin
            s_nxt.txlen = '0;
            s_nxt.rxptr = '0;
          end
          if (pwdata[`SCL_C_START]) begin
            s_nxt.st    = SCL_SEND;
            s_nxt.kind  = K_REQ;
            s_nxt.lead  = `SCL_ENQ;
            s_nxt.ph    = TP_LEAD;
            s_nxt.sum   = 8'h00;
            s_nxt.didx  = '0;
            s_nxt.rxlen = '0;
            s_nxt.rxptr = '0;
            s_nxt.done  = 1'b0;
            s_nxt.nak   = 1'b0;
            s_nxt.serr  = 1'b0;
            s_nxt.tmo   = 1'b0;
            s_nxt.ok    = 1'b0;
          end
        end
        `SCL_A_CMD: s_nxt.cmd = pwdata[15:0];
        `SCL_A_TXDATA: begin
          if (s_r.txlen < (IW+1)'(DEPTH)) begin
            s_nxt.txb[s_r.txlen[IW-1:0]] = pwdata[7:0];
            s_nxt.txlen                  = s_r.txlen + 1'b1;
          end
        end
        default: s_nxt.txlen = s_r.txlen;
      endcase
    end
    // abort only where no character is pending on the tx handshake
    if (apb_go && pwrite && paddr == `SCL_A_CTRL && pwdata[`SCL_C_ABORT]
        && !pwdata[`SCL_C_START] && (s_r.st == SCL_IDLE || s_r.st == SCL_RESP)) begin
      s_nxt.st   = SCL_SEND;
      s_nxt.kind = K_CLR;
      s_nxt.lead = `SCL_CLEAR_CODE;
      s_nxt.ph   = TP_LEAD;
      s_nxt.rph  = RP_HUNT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata   = s_r.prd;
  assign pready   = psel && penable && s_r.pack;
  assign pslverr  = pready && s_r.perr;
  assign tx_valid = s_r.txv;
  assign tx_data  = s_r.txd;
  assign busy     = s_r.st != SCL_IDLE;

endmodule : scl_host

// File: testbench/scl_host_asserts.sv
// Purpose: port checks for the link host controller
// Assumes: one clock, reset active low
// Notes:   field positions counted from each lead character
`timescale 1ns/1ns
module scl_host_asserts #(
  parameter logic [31:0] GAP_CYC = 32'd8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        busy
);
  logic        acc;
  logic        lead;
  logic [7:0]  pos_r;
  logic        enq_r;
  logic        multi_r;
  logic [31:0] quiet_r;
  assign acc  = tx_valid && tx_ready;
  assign lead = acc && (tx_data inside {8'h05, 8'h06, 8'h15});
  // config writes are ignored while busy, so only idle writes count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r   <= 8'h20;
      enq_r   <= 1'b0;
      multi_r <= 1'b0;
      quiet_r <= GAP_CYC;
    end else begin
      if (lead) pos_r <= 8'h00;
      else if (acc && pos_r < 8'h20) pos_r <= pos_r + 8'h01;
      if (lead) enq_r <= (tx_data == 8'h05);
      if (pready && pwrite && paddr == 8'h00 && !busy) multi_r <= pwdata[6];
      if (rx_valid) quiet_r <= 32'h0;
      else if (quiet_r < GAP_CYC) quiet_r <= quiet_r + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("slave error against map");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character dropped before accept");
  a_lead_enq: assert property ($rose(busy) |-> ##[0:2] tx_valid && tx_data == 8'h05)
    else $error("request not led by enquiry");
  a_lf_after_cr: assert property (acc && tx_data == 8'h0d |=> tx_valid && tx_data == 8'h0a)
    else $error("line feed missing");
  a_ctrl_no: assert property (acc && pos_r inside {8'h02, 8'h03} |-> tx_data == 8'h46)
    else $error("controller number wrong");
  a_stn_hex: assert property (acc && pos_r < 8'h02 |-> tx_data inside {[8'h30:8'h39], [8'h41:8'h46]}
    && (pos_r == 8'h01 || tx_data == 8'h30))
    else $error("station field wrong");
  a_wait_digit: assert property (acc && enq_r && pos_r == 8'h06 |-> (!multi_r || tx_data >= 8'h37)
    && tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("wait digit wrong");
  a_cmd_gap: assert property (acc && tx_data == 8'h05 |-> quiet_r >= GAP_CYC)
    else $error("request too soon after reply");
  c_close: cover property (acc && tx_data == 8'h06);
  c_eot: cover property (acc && tx_data == 8'h04);
  c_clear: cover property (acc && tx_data == 8'h0c);
  c_nak: cover property (rx_valid && rx_data == 8'h15);
endmodule : scl_host_asserts

bind scl_host scl_host_asserts #(.GAP_CYC(GAP_CYC)) scl_host_asserts_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .rx_data(rx_data), .busy(busy));

// File: testbench/scl_dev_model.sv
// Purpose: behavioural far-end station for the host bench
// Assumes: whole characters, one rx_valid pulse each
// Notes:   reply delay scaled to 2 cycles per wait step
`timescale 1ns/1ns
module scl_dev_model #(
  parameter logic [3:0] STN = 4'h3
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire logic [1:0] mode,
  input  wire logic       fmt4,
  input  wire logic       sum_en,
  input  wire logic       slow
);
  logic [7:0] rq[$];
  logic [7:0] rp[$];
  int         idle;
  int         wt;
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  task automatic build();
    logic [7:0] s;
    logic       bad;
    int         n;
    s = 8'h00;
    n = rq.size() - (fmt4 ? 2 : 0) - (sum_en ? 2 : 0);
    if (rq[2] !== hx(STN) || mode == 2'd3) return;
    for (int i = 1; i < n; i++) s += rq[i];
    bad = sum_en && {rq[n], rq[n+1]} !== {hx(s[7:4]), hx(s[3:0])};
    // replies to requests keep FF; FE belongs only to unsolicited sends
    if (bad || mode == 2'd2) rp = {8'h15, 8'h30, hx(STN), 8'h46, 8'h46, 8'h30, 8'h36};
    else if (mode == 2'd0) rp = {8'h06, 8'h30, hx(STN), 8'h46, 8'h46};
    else begin
      rp = {8'h30, hx(STN), 8'h46, 8'h46, 8'h41, 8'h42, 8'h03};
      s = 8'h00;
      foreach (rp[i]) s += rp[i];
      if (sum_en) rp = {rp, hx(s[7:4]), hx(s[3:0])};
      rp.push_front(8'h02);
    end
    if (fmt4) rp = {rp, 8'h0d, 8'h0a};
  endtask : build
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq.delete();
      rp.delete();
      idle = 0;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      idle = (tx_valid && tx_ready) ? 0 : idle + 1;
      if (tx_valid && tx_ready) begin
        if (tx_data == 8'h05 || tx_data == 8'h06) rq = {tx_data};
        else if (tx_data == 8'h04 || tx_data == 8'h0c) rq.delete();
        else rq.push_back(tx_data);
      end
      if (rq.size() > 7 && rq[0] == 8'h05) begin
        wt = int'(rq[7]) - (rq[7] > 8'h39 ? 55 : 48);
        if (idle == 4 + 2 * wt) begin
          build();
          rq.delete();
        end
      end
      if (idle > 400) rq.delete();
      // released line toggles so a stale byte never looks valid
      rx_valid <= !rx_valid && rp.size() > 0;
      rx_data  <= (!rx_valid && rp.size() > 0) ? rp.pop_front() : ~rx_data;
    end
  end
endmodule : scl_dev_model

// File: testbench/scl_host_tb.sv
// Purpose: self-checking bench for the link host controller
// Assumes: far-end model answers at station 3
// Notes:   gap and response counts shortened by parameters
`timescale 1ns/1ns
module scl_host_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, tx_valid, tx_ready, rx_valid, busy;
  logic [7:0]  tx_data, rx_data;
  logic [1:0]  mode = 2'd0;
  logic        fmt4 = 1'b0, sum_en = 1'b0, slow = 1'b0;
  logic [31:0] q;
  logic        e;
  logic [7:0]  sent[$];
  int          n_fail = 0, comparisons = 0;
  always #2 pclk = ~pclk;
  scl_host #(.GAP_CYC(32'd8), .RESP_CYC(32'd200)) scl_host_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy));
  scl_dev_model scl_dev_model_i (
    .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .mode(mode),
    .fmt4(fmt4), .sum_en(sum_en), .slow(slow));
  always @(posedge pclk) if (tx_valid === 1'b1 && tx_ready === 1'b1) sent.push_back(tx_data);
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pop(input logic [7:0] ex);
    apb(8'h10, 1'b0, 32'h0);
    chk("rx data", {24'h0, ex}, q);
  endtask : pop
  // one whole exchange; ends with the status word in q
  task automatic run(input logic f4, input logic sm, input logic rd, input logic mu,
                     input logic [3:0] wt, input logic [1:0] md, input logic ab);
    logic [7:0] x[$];
    logic [7:0] s;
    int         k;
    x = {8'h05, 8'h30, hx(4'h3), 8'h46, 8'h46, 8'h51, 8'h52,
         hx((mu && wt < 4'h7) ? 4'h7 : wt), 8'h31, 8'h32};
    s = 8'h00;
    for (k = 1; k < x.size(); k++) s += x[k];
    if (sm) x = {x, hx(s[7:4]), hx(s[3:0])};
    if (f4) x = {x, 8'h0d, 8'h0a};
    fmt4   <= f4;
    sum_en <= sm;
    slow   <= rd;
    mode   <= md;
    sent.delete();
    // start keeps the payload count, so empty it first
    apb(8'h00, 1'b1, 32'h20);
    apb(8'h08, 1'b1, 32'h31);
    apb(8'h08, 1'b1, 32'h32);
    apb(8'h04, 1'b1, 32'h5152);
    apb(8'h00, 1'b1, {16'h0, wt, 4'h3, 1'b0, mu, 2'b00, rd, sm, f4, 1'b1});
    if (ab) begin
      for (k = 0; k < 500 && sent.size() < x.size(); k++) @(posedge pclk);
      apb(8'h00, 1'b1, 32'h10);
      x.push_back(8'h0c);
    end else if (md == 2'd3) x.push_back(8'h04);
    else if (md == 2'd1 && rd) begin
      x = {x, 8'h06, 8'h30, hx(4'h3), 8'h46, 8'h46};
      if (f4) x = {x, 8'h0d, 8'h0a};
    end
    @(posedge pclk);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge pclk);
    chk("busy", 32'h0, {31'h0, busy});
    chk("tx count", x.size(), sent.size());
    foreach (x[i]) chk("tx char", {24'h0, x[i]}, (i < sent.size()) ? {24'h0, sent[i]} : 32'hx);
    apb(8'h0c, 1'b0, 32'h0);
  endtask : run
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h0c, 1'b0, 32'h0);
    chk("status reset", 32'h0, q);
    apb(8'h14, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    run(1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 2'd0, 1'b0);
    chk("write status", 32'h22, q & 32'h23);
    run(1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 2'd1, 1'b0);
    chk("read status", 32'h02, q & 32'h1f);
    pop(8'h41);
    pop(8'h42);
    pop(8'h00);
    run(1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 2'd2, 1'b0);
    chk("nak status", 32'h04, q & 32'h15);
    pop(8'h30);
    pop(8'h36);
    run(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 2'd3, 1'b0);
    chk("timeout status", 32'h10, q & 32'h15);
    run(1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 2'd3, 1'b1);
    chk("abort status", 32'h02, q & 32'h17);
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
endmodule : scl_host_tb
